// >>> wake_timer_pkg.sv
// Constants for the wake-up interval timer register block
package wake_timer_pkg;

	// =========================================================
	// Register byte offsets
	localparam logic [7:0] OFFS_COUNTER    = 8'h00;
	localparam logic [7:0] OFFS_CONFIG     = 8'h04;
	localparam logic [7:0] OFFS_EXT_CONFIG = 8'h08;
	localparam logic [7:0] OFFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFFS_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] OFFS_IRQ_ENABLE = 8'h14;

	// =========================================================
	// Config field positions
	localparam int CFG_RUN_BIT  = 7;
	localparam int CFG_DIV_HI   = 6;
	localparam int CFG_DIV_LO   = 3;
	localparam int CFG_SRC_BIT  = 2;
	localparam int CFG_IE_BIT   = 1;
	localparam int CFG_FLAG_BIT = 0;
	localparam int EXTENDED_CONFIG_DIRECT_BIT = 0;

	// =========================================================
	// Event bits and reset values
	localparam int EVT_OVERFLOW_BIT = 0;
	localparam logic [7:0] COUNTER_RESET   = 8'h00;
	localparam logic [7:0] CONFIG_RESET    = 8'h00;
	localparam logic       DIRECT_RESET    = 1'b0;
	localparam logic [7:0] IRQ_EN_RESET    = 8'h00;

	// =========================================================
	// Widths
	localparam int COUNT_WIDTH = 8;
	localparam int PRESCALE_WIDTH = 15;

endpackage : wake_timer_pkg

// >>> wakeup_interval_timer.sv
// Wake-up interval timer with prescaler, source select and APB registers
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module wakeup_interval_timer
	import wake_timer_pkg::*;
#(
	parameter int COUNT_W    = COUNT_WIDTH,
	parameter int PRESCALE_W = PRESCALE_WIDTH
)
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Clock sources
	input  wire logic        external_wake_clock_i,
	input  wire logic        pre_pll_clock_i,
	// Interrupts
	output logic             wake_irq_o,
	output logic             irq_o
);

	// =========================================================
	// Elaboration checks
	// Reads return one byte, and the divider field reaches bit 14
	generate
		if (COUNT_W != 8)
		begin : g_bad_count
			$error("count width must be 8");
		end
		if (PRESCALE_W < 15 || PRESCALE_W > 16)
		begin : g_bad_prescale
			$error("prescale width must be 15 or 16");
		end
	endgenerate

	// =========================================================
	// Reset synchroniser
	logic reset_meta_n;
	logic reset_n;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reset_meta_n <= 1'b0;
			reset_n      <= 1'b0;
		end
		else
		begin
			reset_meta_n <= 1'b1;
			reset_n      <= reset_meta_n;
		end
	end

	// =========================================================
	// Input synchronisers and edge detection
	logic [1:0] ext_sync;
	logic [1:0] pll_sync;
	logic       ext_last;
	logic       pll_last;

	// Two flops per pin; only the second stage is read by logic
	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_sync <= 2'h0;
			pll_sync <= 2'h0;
		end
		else
		begin
			ext_sync <= {ext_sync[0], external_wake_clock_i};
			pll_sync <= {pll_sync[0], pre_pll_clock_i};
		end
	end

	// Reset low matches the idle pin level, so no false edge after reset
	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ext_last <= 1'b0;
			pll_last <= 1'b0;
		end
		else
		begin
			ext_last <= ext_sync[1];
			pll_last <= pll_sync[1];
		end
	end

	// =========================================================
	// Registers
	logic [COUNT_W-1:0]    wake_counter_value;
	logic [7:0]            wake_timer_config;
	logic [7:0]            next_wake_timer_config;
	logic                  direct_clock_select;
	logic [7:0]            irq_status;
	logic [7:0]            next_irq_status;
	logic [7:0]            irq_event;
	logic [7:0]            irq_enable;
	logic [PRESCALE_W-1:0] prescale;

	logic       wake_run_enable;
	logic [3:0] wake_divider_select;
	logic       wake_source_select;
	logic       wake_irq_enable;
	logic       wake_overflow_flag;

	assign wake_run_enable     = wake_timer_config[CFG_RUN_BIT];
	assign wake_divider_select = wake_timer_config[CFG_DIV_HI:CFG_DIV_LO];
	assign wake_source_select  = wake_timer_config[CFG_SRC_BIT];
	assign wake_irq_enable     = wake_timer_config[CFG_IE_BIT];
	assign wake_overflow_flag  = wake_timer_config[CFG_FLAG_BIT];

	// =========================================================
	// Source edge, prescaler tick, overflow
	logic ext_edge;
	logic pll_edge;
	logic src_edge;
	logic tick;
	logic overflow;
	logic [PRESCALE_W-1:0] div_mask;

	// Low N prescaler bits all ones marks the last edge of a period
	function automatic logic [PRESCALE_W-1:0] divider_mask(input logic [3:0] sel);
		logic [16:0] full;
		full = (17'h00001 << sel) - 17'h00001;
		divider_mask = PRESCALE_W'(full);
	endfunction : divider_mask

	// Both ext modes count rising edges; single clock means direct mode
	// shares the synchroniser, so the 2x rate limit applies to it too.
	assign ext_edge = ext_sync[1] & ~ext_last;
	assign pll_edge = pll_sync[1] & ~pll_last;
	assign src_edge = wake_run_enable & (wake_source_select ? ext_edge : pll_edge);
	assign div_mask = divider_mask(wake_divider_select);
	assign tick     = src_edge & ((prescale & div_mask) == div_mask);
	assign overflow = tick & (wake_counter_value == {COUNT_W{1'b1}});

	// =========================================================
	// APB decode
	logic bus_write;
	logic bus_read;
	logic mapped;

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == OFFS_COUNTER) || (addr == OFFS_CONFIG) ||
			(addr == OFFS_EXT_CONFIG) || (addr == OFFS_IRQ_STATUS) ||
			(addr == OFFS_IRQ_CLEAR) || (addr == OFFS_IRQ_ENABLE);
	endfunction : is_mapped

	assign mapped    = is_mapped(paddr_i);
	assign bus_write = psel_i & penable_i & pwrite_i & mapped;
	assign bus_read  = psel_i & penable_i & ~pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	// =========================================================
	// Register strobes, one per writable register, plus the read setup strobe
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
		hit = (addr == offs);
	endfunction : hit

	logic wr_counter;
	logic wr_config;
	logic wr_ext_config;
	logic wr_irq_clear;
	logic wr_irq_enable;
	logic rd_setup;

	assign wr_counter    = bus_write & hit(paddr_i, OFFS_COUNTER);
	assign wr_config     = bus_write & hit(paddr_i, OFFS_CONFIG);
	assign wr_ext_config = bus_write & hit(paddr_i, OFFS_EXT_CONFIG);
	assign wr_irq_clear  = bus_write & hit(paddr_i, OFFS_IRQ_CLEAR);
	assign wr_irq_enable = bus_write & hit(paddr_i, OFFS_IRQ_ENABLE);
	// Data is fetched in the setup cycle so it stands for the access
	assign rd_setup      = psel_i & ~penable_i & ~pwrite_i;

	// =========================================================
	// Prescaler
	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			prescale <= '0;
		else if (src_edge)
			prescale <= prescale + 1'b1;
	end

	// =========================================================
	// Counter
	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			wake_counter_value <= COUNTER_RESET;
		else if (wr_counter)
			wake_counter_value <= pwdata_i[COUNT_W-1:0];
		else if (tick)
			wake_counter_value <= wake_counter_value + 1'b1;
	end

	// =========================================================
	// Config and flag; a new overflow beats a clearing write
	always_comb
	begin
		next_wake_timer_config = wake_timer_config;
		if (wr_config)
		begin
			next_wake_timer_config[7:1] = pwdata_i[7:1];
			if (!pwdata_i[CFG_FLAG_BIT])
				next_wake_timer_config[CFG_FLAG_BIT] = 1'b0;
		end
		if (overflow)
			next_wake_timer_config[CFG_FLAG_BIT] = 1'b1;
	end

	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			wake_timer_config <= CONFIG_RESET;
		else
			wake_timer_config <= next_wake_timer_config;
	end

	// Stored only; direct mode shares the sampled edge path here
	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			direct_clock_select <= DIRECT_RESET;
		else if (wr_ext_config)
			direct_clock_select <= pwdata_i[EXTENDED_CONFIG_DIRECT_BIT];
	end

	// =========================================================
	// Interrupt status, clear and enable
	always_comb
	begin
		irq_event                   = 8'h00;
		irq_event[EVT_OVERFLOW_BIT] = overflow;
	end

	// Sticky bits; an event in the clearing cycle wins
	always_comb
	begin
		next_irq_status = irq_status;
		for (int b = 0; b < 8; b++)
		begin
			if (irq_event[b])
				next_irq_status[b] = 1'b1;
			else if (wr_irq_clear && pwdata_i[b])
				next_irq_status[b] = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			irq_status <= 8'h00;
		else
			irq_status <= next_irq_status;
	end

	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			irq_enable <= IRQ_EN_RESET;
		else if (wr_irq_enable)
			irq_enable <= pwdata_i[7:0];
	end

	assign wake_irq_o = wake_overflow_flag & wake_irq_enable;
	assign irq_o      = |(irq_status & irq_enable);

	// =========================================================
	// Read data register
	// Clear register and unmapped words read as zero
	function automatic logic [31:0] read_mux(
		input logic [7:0] addr,
		input logic [7:0] counter,
		input logic [7:0] cfg_value,
		input logic       direct,
		input logic [7:0] status,
		input logic [7:0] enable
	);
		case (addr)
			OFFS_COUNTER:    read_mux = {24'h000000, counter};
			OFFS_CONFIG:     read_mux = {24'h000000, cfg_value};
			OFFS_EXT_CONFIG: read_mux = {31'h00000000, direct};
			OFFS_IRQ_STATUS: read_mux = {24'h000000, status};
			OFFS_IRQ_ENABLE: read_mux = {24'h000000, enable};
			default:         read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	always_ff @(posedge clk_i or negedge reset_n)
	begin
		if (!reset_n)
			prdata_o <= 32'h0000_0000;
		else if (rd_setup)
			prdata_o <= read_mux(paddr_i, wake_counter_value, wake_timer_config,
				direct_clock_select, irq_status, irq_enable);
		else if (!bus_read)
			prdata_o <= 32'h0000_0000;
	end

endmodule : wakeup_interval_timer

// >>> wake_timer_chk.sv
// Port checker for the wake-up interval timer
`timescale 1ns/100ps
module wake_timer_chk
	import wake_timer_pkg::*;
(
	// Watched ports
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        wake_irq_o,
	input wire logic        irq_o
);
	// ============
	// Access decode
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic acc;
	logic wr;
	logic cfg_wr;
	assign acc = psel_i && penable_i;
	assign wr = acc && pwrite_i;
	assign cfg_wr = wr && paddr_i == OFFS_CONFIG;
	// ============
	// Properties
	rdy_a: assert property (acc |-> pready_o) else $error("wait state");
	bad_addr_a: assert property (acc && paddr_i > OFFS_IRQ_ENABLE |-> pslverr_o)
		else $error("no slave error");
	map_ok_a: assert property (
		acc && paddr_i <= OFFS_IRQ_ENABLE && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
		else $error("false slave error");
	rd_zero_a: assert property (
		acc && !pwrite_i && paddr_i > OFFS_IRQ_ENABLE |-> prdata_o == 32'h0)
		else $error("unmapped data");
	ie_off_a: assert property (cfg_wr && !pwdata_i[CFG_IE_BIT] |=> !wake_irq_o)
		else $error("request while disabled");
	flag_hold_a: assert property (wake_irq_o && !cfg_wr |=> wake_irq_o)
		else $error("flag lost");
	en_off_a: assert property (
		wr && paddr_i == OFFS_IRQ_ENABLE && !pwdata_i[0] |=> !irq_o)
		else $error("irq while masked");
	irq_clr_a: assert property (
		wr && paddr_i == OFFS_IRQ_CLEAR && pwdata_i[EVT_OVERFLOW_BIT] |=> !irq_o)
		else $error("irq not cleared");
endmodule : wake_timer_chk

bind wakeup_interval_timer wake_timer_chk chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.wake_irq_o(wake_irq_o), .irq_o(irq_o));

// >>> wake_clock_source.sv
// Slow clock sources feeding the wake-up timer
`timescale 1ns/100ps
module wake_clock_source
#(
	parameter int HALF_NS = 130
)
(
	// Clocks, low between bursts
	output logic ext_clock_o,
	output logic pll_clock_o
);
	// ============
	// Burst of rising edges on one source
	initial
	begin
		ext_clock_o = 1'b0;
		pll_clock_o = 1'b0;
	end
	// Period well over two system clocks, so every edge is seen
	task automatic burst(input logic use_ext, input int edges);
		repeat (edges)
		begin
			#(HALF_NS);
			ext_clock_o = use_ext;
			pll_clock_o = !use_ext;
			#(HALF_NS);
			ext_clock_o = 1'b0;
			pll_clock_o = 1'b0;
		end
	endtask : burst
endmodule : wake_clock_source

// >>> test_wakeup_interval_timer.sv
// Self-checking bench for the wake-up interval timer
`timescale 1ns/100ps
module test_wakeup_interval_timer
	import wake_timer_pkg::*;
;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic        ext_clock, pll_clock, wake_irq, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] rnd = 32'h854C;
	int          err_total = 0;
	int          n_compared = 0;
	wakeup_interval_timer wakeup_interval_timer_inst (.clk_i(clk), .reset_n_i(reset_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.external_wake_clock_i(ext_clock), .pre_pll_clock_i(pll_clock),
		.wake_irq_o(wake_irq), .irq_o(irq));
	wake_clock_source wake_clock_source_inst (.ext_clock_o(ext_clock), .pll_clock_o(pll_clock));
	// ============
	// Helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// Bit 8 is the overflow
	function automatic logic [8:0] count_after(logic [7:0] v, int k, logic [3:0] n, logic run);
		return run ? 9'(int'(v) + (k >> n)) : {1'b0, v};
	endfunction : count_after
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i == 50)
		begin
			check(1'b0, 1'b1);
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// ============
	// Main sequence
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		check(1'b0, 1'b1);
		end_of_test();
	end
	initial
	begin
		logic [7:0] v;
		logic [3:0] n;
		logic [8:0] exp9;
		logic       src, ie, en, run;
		int         k;
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, OFFS_CONFIG, 32'h0);
		check(rd, {24'h0, CONFIG_RESET});
		apb(1'b0, OFFS_IRQ_ENABLE, 32'h0);
		check(rd, {24'h0, IRQ_EN_RESET});
		apb(1'b0, 8'h18, 32'h0);
		check({rd[30:0], err}, 32'h1);
		for (int t = 0; t < 10; t++)
		begin
			rnd = lfsr_next(rnd);
			v = (t == 0) ? 8'hFF : rnd[7:0];
			n = (t == 0) ? 4'h0 : {2'h0, rnd[9:8]};
			{en, ie, src} = rnd[12:10];
			run = (t == 0) | rnd[13];
			k = 8 * (1 + int'(rnd[15:14]));
			exp9 = count_after(v, k, n, run);
			apb(1'b1, OFFS_COUNTER, {24'h0, v});
			apb(1'b1, OFFS_IRQ_ENABLE, {31'h0, en});
			apb(1'b1, OFFS_EXT_CONFIG, {31'h0, rnd[16]});
			apb(1'b1, OFFS_CONFIG, {24'h0, run, n, src, ie, 1'b1});
			wake_clock_source_inst.burst(src, k);
			repeat (8) @(posedge clk);
			apb(1'b0, OFFS_EXT_CONFIG, 32'h0);
			check(rd, {31'h0, rnd[16]});
			apb(1'b1, OFFS_EXT_CONFIG, 32'h0);
			apb(1'b0, OFFS_COUNTER, 32'h0);
			check(rd, {24'h0, exp9[7:0]});
			apb(1'b0, OFFS_CONFIG, 32'h0);
			check(rd, {24'h0, run, n, src, ie, exp9[8]});
			apb(1'b0, OFFS_IRQ_STATUS, 32'h0);
			check(rd, {31'h0, exp9[8]});
			check({wake_irq, irq}, {exp9[8] & ie, exp9[8] & en});
			apb(1'b1, OFFS_CONFIG, 32'h0);
			apb(1'b1, OFFS_IRQ_CLEAR, 32'h1);
			apb(1'b0, OFFS_CONFIG, 32'h0);
			check(rd, 32'h0);
		end
		end_of_test();
	end
endmodule : test_wakeup_interval_timer
